/* File: include/mss_pkg.sv */
`default_nettype none
package mss_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0]  MSS_OFS_STRAP  = 8'h00;
  localparam logic [7:0]  MSS_OFS_CTRL   = 8'h04;
  localparam logic [7:0]  MSS_OFS_MODE   = 8'h08;
  localparam logic [7:0]  MSS_OFS_FRAMES = 8'h0C;

  // Control register fields and reset value
  localparam int          MSS_CTRL_DUP_BIT = 0;
  localparam int          MSS_CTRL_FC_BIT  = 1;
  localparam logic [1:0]  MSS_CTRL_RESET   = 2'h0;

  // Mode register field positions
  localparam int          MSS_MODE_ROLE_LSB = 4;
  localparam int          MSS_MODE_CAP_BIT  = 8;

  // Maximum frame lengths: 1518, 1522 and 1536 bytes
  localparam logic [10:0] MSS_LEN_STD      = 11'h5EE;
  localparam logic [10:0] MSS_LEN_STD_TAG  = 11'h5F2;
  localparam logic [10:0] MSS_LEN_LONG     = 11'h600;

  // Dual-MII configuration code bit that enables the port-5 MII
  localparam int          MSS_MODE_P5_BIT  = 2;
  localparam logic [2:0]  MSS_MODE_RESET   = 3'h0;
  localparam logic [15:0] MSS_FRAMES_RESET = 16'h0000;

  typedef enum logic [1:0] {
    MSS_ROLE_OFF     = 2'b00,
    MSS_ROLE_PHY_MII = 2'b01,
    MSS_ROLE_MAC_MII = 2'b10,
    MSS_ROLE_PHY_SNI = 2'b11
  } mss_role_t;

  // Port-5 PHY-mode MII receive side pins
  typedef struct packed {
    logic [3:0] nibble;
    logic       symbol_error;
    logic       carrier_sense;
    logic       collision;
  } mss_p5_mii_t;

  // Switch MII receive side pins
  typedef struct packed {
    logic       valid;
    logic [3:0] nibble;
    logic       collision;
    logic       carrier_sense;
  } mss_sw_rx_t;

  // Switch MII transmit side pins
  typedef struct packed {
    logic       enable;
    logic [3:0] nibble;
    logic       error;
  } mss_sw_tx_t;

  typedef struct packed {
    logic tx_clock;
    logic rx_clock;
  } mss_sw_clk_t;

  // Levels caught on the strap pins
  typedef struct packed {
    logic back_pressure_en;
    logic keep_excess_coll;
    logic aggressive_backoff;
    logic long_frames;
    logic sw_flow_ctrl_en;
    logic sw_half_duplex;
    logic sw_10mbps;
    logic sw_rx_bit0;
    logic p5_duplex;
    logic p5_flow_ctrl;
  } mss_strap_t;

  localparam mss_strap_t  MSS_STRAP_RESET = 10'h000;

  // MAC options handed to the switch core
  typedef struct packed {
    logic        back_pressure_en;
    logic        keep_excess_coll;
    logic        aggressive_backoff;
    logic [10:0] max_len_untagged;
    logic [10:0] max_len_tagged;
    logic        sw_flow_ctrl_en;
    logic        sw_half_duplex;
    logic        sw_10mbps;
    logic        p5_force_duplex;
    logic        p5_force_flow_ctrl;
    mss_role_t   role;
  } mss_cfg_t;

endpackage : mss_pkg
`default_nettype wire

/* File: hdl/mss_sampler.sv */
`default_nettype none
module mss_sampler (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic [2:0]           sw_mode_code,
  input  wire mss_pkg::mss_p5_mii_t p5_pin_i,
  output mss_pkg::mss_p5_mii_t      p5_pin_o,
  output mss_pkg::mss_p5_mii_t      p5_pin_oe,
  input  wire mss_pkg::mss_p5_mii_t p5_core_rx,
  input  wire logic                 sw_link_clock,
  input  wire mss_pkg::mss_sw_rx_t  sw_rx_pin_i,
  output mss_pkg::mss_sw_rx_t       sw_rx_pin_o,
  output mss_pkg::mss_sw_rx_t       sw_rx_pin_oe,
  input  wire mss_pkg::mss_sw_rx_t  sw_core_rx,
  input  wire mss_pkg::mss_sw_tx_t  sw_tx_pin_i,
  output mss_pkg::mss_sw_tx_t       sw_core_tx,
  output mss_pkg::mss_sw_clk_t      sw_clk_o,
  output mss_pkg::mss_sw_clk_t      sw_clk_oe,
  output mss_pkg::mss_cfg_t         cfg
);
  import mss_pkg::*;

  mss_strap_t  strap_raw;
  mss_strap_t  strap_sync1_reg;
  mss_strap_t  strap_sync2_reg;
  mss_strap_t  straps_reg;
  logic [2:0]  mode_sync1_reg;
  logic [2:0]  mode_sync2_reg;
  logic [2:0]  mode_reg;
  logic        captured_reg;
  logic [1:0]  ctrl_reg;
  logic [15:0] frames_reg;
  mss_role_t   role;
  mss_cfg_t    cfg_next;
  mss_cfg_t    cfg_reg;
  logic        p5_oe_reg;
  mss_p5_mii_t p5_out_reg;
  logic        clk_div_reg;
  logic        clk_oe_reg;
  logic        sw_drive_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] rdata_reg;
  logic        take;
  logic        link_rst1_reg;
  logic        link_rstn_reg;
  logic        drive_sync1_reg;
  logic        drive_link_reg;
  mss_sw_rx_t  sw_rx_out_reg;
  mss_sw_tx_t  sw_tx_reg;
  logic        tx_en_prev_reg;
  logic        frame_tgl_reg;
  logic        tgl_sync1_reg;
  logic        tgl_sync2_reg;
  logic        tgl_sync3_reg;

  // Role of the switch MII from the low two code bits
  function automatic mss_role_t role_of(input logic [2:0] code);
    unique case (code[1:0])
      2'b01:   role_of = MSS_ROLE_PHY_MII;
      2'b10:   role_of = MSS_ROLE_MAC_MII;
      2'b11:   role_of = MSS_ROLE_PHY_SNI;
      default: role_of = MSS_ROLE_OFF;
    endcase
  endfunction : role_of

  // Register read decode; unmapped words read zero
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    read_word = 32'h0000_0000;
    unique case (addr)
      MSS_OFS_STRAP:  read_word[9:0] = straps_reg;
      MSS_OFS_CTRL:   read_word[1:0] = ctrl_reg;
      MSS_OFS_MODE:   read_word = {23'h000000, captured_reg, 2'h0, role, 1'h0, mode_reg};
      MSS_OFS_FRAMES: read_word[15:0] = frames_reg;
      default:        read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  // Strap pins, pulled down by the pad while the drivers are off
  assign strap_raw = '{
    back_pressure_en:   p5_pin_i.nibble[2],
    keep_excess_coll:   p5_pin_i.nibble[1],
    aggressive_backoff: p5_pin_i.nibble[0],
    long_frames:        p5_pin_i.symbol_error,
    sw_flow_ctrl_en:    sw_rx_pin_i.nibble[3],
    sw_half_duplex:     sw_rx_pin_i.nibble[2],
    sw_10mbps:          sw_rx_pin_i.nibble[1],
    sw_rx_bit0:         sw_rx_pin_i.nibble[0],
    p5_duplex:          p5_pin_i.carrier_sense,
    p5_flow_ctrl:       p5_pin_i.collision
  };

  // Pin synchronisers; no reset so they keep sampling while reset is held
  always_ff @(posedge hclk) begin
    strap_sync1_reg <= strap_raw;
    strap_sync2_reg <= strap_sync1_reg;
    mode_sync1_reg  <= sw_mode_code;
    mode_sync2_reg  <= mode_sync1_reg;
  end

  // Capture flag rises on the first edge after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      captured_reg <= 1'b0;
    end else begin
      captured_reg <= 1'b1;
    end
  end

  // Levels seen during reset are frozen until the next reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      straps_reg <= MSS_STRAP_RESET;
      mode_reg   <= MSS_MODE_RESET;
    end else if (!captured_reg) begin
      straps_reg <= strap_sync2_reg;
      mode_reg   <= mode_sync2_reg;
    end
  end

  assign role = role_of(mode_reg);

  // Options for the MAC core, from the frozen straps
  always_comb begin
    cfg_next                    = '0;
    cfg_next.back_pressure_en   = straps_reg.back_pressure_en;
    cfg_next.keep_excess_coll   = straps_reg.keep_excess_coll;
    cfg_next.aggressive_backoff = straps_reg.aggressive_backoff;
    cfg_next.max_len_untagged   = straps_reg.long_frames ? MSS_LEN_LONG : MSS_LEN_STD;
    cfg_next.max_len_tagged     = straps_reg.long_frames ? MSS_LEN_LONG : MSS_LEN_STD_TAG;
    cfg_next.sw_flow_ctrl_en    = straps_reg.sw_flow_ctrl_en;
    cfg_next.sw_half_duplex     = straps_reg.sw_half_duplex;
    cfg_next.sw_10mbps          = straps_reg.sw_10mbps;
    // Forcing only takes effect when software qualifies it
    cfg_next.p5_force_duplex    = straps_reg.p5_duplex & ctrl_reg[MSS_CTRL_DUP_BIT];
    cfg_next.p5_force_flow_ctrl = straps_reg.p5_flow_ctrl & ctrl_reg[MSS_CTRL_FC_BIT];
    cfg_next.role               = role;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign cfg = cfg_reg;

  // Port-5 drivers wake one edge after capture, only when the code enables port 5
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p5_oe_reg  <= 1'b0;
      p5_out_reg <= '0;
    end else begin
      p5_oe_reg  <= captured_reg & mode_reg[MSS_MODE_P5_BIT];
      p5_out_reg <= p5_oe_reg ? p5_core_rx : '0;
    end
  end

  assign p5_pin_o  = p5_out_reg;
  assign p5_pin_oe = {$bits(mss_p5_mii_t){p5_oe_reg}};

  // PHY mode: device sources both MII clocks at half the bus clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_div_reg  <= 1'b0;
      clk_oe_reg   <= 1'b0;
      sw_drive_reg <= 1'b0;
    end else begin
      clk_div_reg  <= ~clk_div_reg;
      clk_oe_reg   <= captured_reg & ((role == MSS_ROLE_PHY_MII) | (role == MSS_ROLE_PHY_SNI));
      sw_drive_reg <= captured_reg & (role != MSS_ROLE_OFF);
    end
  end

  assign sw_clk_o  = '{tx_clock: clk_div_reg, rx_clock: clk_div_reg};
  assign sw_clk_oe = '{tx_clock: clk_oe_reg, rx_clock: clk_oe_reg};

  // AHB-Lite slave: zero wait states, always OKAY
  // htrans[1] covers NONSEQ and SEQ; IDLE and BUSY start nothing
  assign take      = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // Address phase: latch writes, prefetch read data for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= take & hwrite & (hsize == 3'h2);
      if (take) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (take & !hwrite) begin
        rdata_reg <= read_word(haddr[7:0]);
      end
    end
  end

  // Data phase write; only the control word is writable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= MSS_CTRL_RESET;
    end else if (wr_pend_reg && (wr_addr_reg == MSS_OFS_CTRL)) begin
      ctrl_reg <= hwdata[1:0];
    end
  end

  // Link reset: asserted at once, released on the link clock
  always_ff @(posedge sw_link_clock or negedge hresetn) begin
    if (!hresetn) begin
      link_rst1_reg <= 1'b0;
      link_rstn_reg <= 1'b0;
    end else begin
      link_rst1_reg <= 1'b1;
      link_rstn_reg <= link_rst1_reg;
    end
  end

  // Drive enable carried into the link domain as a level
  always_ff @(posedge sw_link_clock or negedge link_rstn_reg) begin
    if (!link_rstn_reg) begin
      drive_sync1_reg <= 1'b0;
      drive_link_reg  <= 1'b0;
    end else begin
      drive_sync1_reg <= sw_drive_reg;
      drive_link_reg  <= drive_sync1_reg;
    end
  end

  // Switch MII receive outputs, launched on the link clock
  always_ff @(posedge sw_link_clock or negedge link_rstn_reg) begin
    if (!link_rstn_reg) begin
      sw_rx_out_reg <= '0;
    end else begin
      sw_rx_out_reg <= drive_link_reg ? sw_core_rx : '0;
    end
  end

  assign sw_rx_pin_o  = sw_rx_out_reg;
  assign sw_rx_pin_oe = {$bits(mss_sw_rx_t){drive_link_reg}};

  // Partner transmit pins are synchronous to the link clock
  always_ff @(posedge sw_link_clock or negedge link_rstn_reg) begin
    if (!link_rstn_reg) begin
      sw_tx_reg      <= '0;
      tx_en_prev_reg <= 1'b0;
      frame_tgl_reg  <= 1'b0;
    end else begin
      sw_tx_reg      <= sw_tx_pin_i;
      tx_en_prev_reg <= sw_tx_reg.enable;
      if (sw_tx_reg.enable & !tx_en_prev_reg) begin
        frame_tgl_reg <= ~frame_tgl_reg;
      end
    end
  end

  assign sw_core_tx = sw_tx_reg;

  // Frame starts cross by toggle; works although the link clock may stop
  // Third flop only keeps the previous level for the edge compare
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgl_sync1_reg <= 1'b0;
      tgl_sync2_reg <= 1'b0;
      tgl_sync3_reg <= 1'b0;
    end else begin
      tgl_sync1_reg <= frame_tgl_reg;
      tgl_sync2_reg <= tgl_sync1_reg;
      tgl_sync3_reg <= tgl_sync2_reg;
    end
  end

  // Frame counter wraps silently at 16 bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frames_reg <= MSS_FRAMES_RESET;
    end else if (tgl_sync2_reg ^ tgl_sync3_reg) begin
      frames_reg <= frames_reg + 16'h0001;
    end
  end

  // Checks below default to the bus clock and are off while reset is held
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_oe_after_capture: assert property (p5_oe_reg |-> captured_reg && $past(captured_reg))
    else $error("port-5 driver enabled before straps were caught");
  a_strap_hold: assert property (captured_reg && $past(captured_reg) |-> $stable(straps_reg))
    else $error("strap levels changed after capture");
  a_back_pressure: assert property (##1 cfg_reg.back_pressure_en == $past(straps_reg.back_pressure_en))
    else $error("back pressure option does not follow its strap");
  a_excess_coll: assert property (##1 cfg_reg.keep_excess_coll == $past(straps_reg.keep_excess_coll))
    else $error("excess collision option does not follow its strap");
  a_backoff_opt: assert property (##1 cfg_reg.aggressive_backoff == $past(straps_reg.aggressive_backoff))
    else $error("back-off option does not follow its strap");
  a_max_length: assert property (straps_reg.long_frames |=> cfg_reg.max_len_untagged == 11'h600
    && cfg_reg.max_len_tagged == 11'h600)
    else $error("long frame strap did not give 1536 bytes");
  // Options read zero until capture, so the length check waits for it
  a_std_length: assert property (captured_reg && !straps_reg.long_frames |=> cfg_reg.max_len_untagged == 11'h5EE
    && cfg_reg.max_len_tagged == 11'h5F2)
    else $error("standard frame length wrong");
  a_sw_options: assert property (##1 {cfg_reg.sw_flow_ctrl_en, cfg_reg.sw_half_duplex, cfg_reg.sw_10mbps}
    == $past({straps_reg.sw_flow_ctrl_en, straps_reg.sw_half_duplex, straps_reg.sw_10mbps}))
    else $error("switch MII flow, duplex or speed option wrong");
  a_p5_data_path: assert property ($past(p5_oe_reg) |-> p5_pin_o == $past(p5_core_rx))
    else $error("port-5 receive pins do not carry core data");
  a_force_qualify: assert property (!ctrl_reg[0] && !ctrl_reg[1] |=> !cfg_reg.p5_force_duplex
    && !cfg_reg.p5_force_flow_ctrl)
    else $error("forcing active without control qualification");
  a_clock_drive: assert property (##1 sw_clk_oe.tx_clock == ($past(captured_reg)
    && ($past(role) == MSS_ROLE_PHY_MII || $past(role) == MSS_ROLE_PHY_SNI)))
    else $error("switch MII clock driver does not follow role");
  a_role_decode: assert property (captured_reg && mode_reg[1:0] == 2'b00 |-> role == MSS_ROLE_OFF
    ##2 !sw_clk_oe.rx_clock && !sw_drive_reg)
    else $error("disabled role still drives the switch MII");

  // Frame counter moves only on a crossed frame start
  a_frame_count: assert property ((tgl_sync2_reg ^ tgl_sync3_reg) |=> frames_reg == $past(frames_reg) + 16'h0001)
    else $error("frame start not counted");
  a_frame_idle: assert property (!(tgl_sync2_reg ^ tgl_sync3_reg) |=> $stable(frames_reg))
    else $error("frame count moved without a frame start");

  // Link-side checks carry their own clock and the link reset
  a_sw_rx_path: assert property (@(posedge sw_link_clock) disable iff (!link_rstn_reg)
    $past(drive_link_reg) |-> sw_rx_pin_o == $past(sw_core_rx))
    else $error("switch receive pins do not carry core data");
  a_tx_capture: assert property (@(posedge sw_link_clock) disable iff (!link_rstn_reg)
    $past(link_rstn_reg) |-> sw_core_tx == $past(sw_tx_pin_i))
    else $error("switch transmit pins not passed to the core");

  // Main scenarios worth seeing at least once

  c_long_frames: cover property (captured_reg && straps_reg.long_frames);
  c_phy_mode: cover property (sw_clk_oe.tx_clock && p5_oe_reg);
  c_frame_seen: cover property (frames_reg != 16'h0000);
  c_ctrl_write: cover property (wr_pend_reg && wr_addr_reg == MSS_OFS_CTRL);
  c_mac_role: cover property (captured_reg && role == MSS_ROLE_MAC_MII);

endmodule : mss_sampler
`default_nettype wire

/* File: tb/mss_mac_model.sv */
`default_nettype none
module mss_mac_model (
  input  wire logic          link_clk,
  input  wire logic          rst_n,
  input  wire logic [7:0]    n_req,
  output mss_pkg::mss_sw_tx_t tx,
  output logic [7:0]         n_sent
);
  timeunit 1ns;
  timeprecision 1ps;
  import mss_pkg::*;

  logic [2:0] step_reg;

  // Frame sequencer on the free-running link clock; three idle clocks between frames
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_reg <= 3'h0;
      n_sent   <= 8'h00;
    end else if (step_reg != 3'h0 || n_sent != n_req) begin
      step_reg <= step_reg + 3'h1;
      if (step_reg == 3'h7) begin
        n_sent <= n_sent + 8'h01;
      end
    end
  end

  // Five nibbles per frame; idle pins fall to the pull-down level, not the last value
  always_comb begin
    tx.enable = (step_reg != 3'h0) && (step_reg < 3'h6);
    tx.nibble = tx.enable ? ({1'b0, step_reg} ^ {n_sent[0], 3'h0}) : 4'h0;
    tx.error  = tx.enable && (step_reg == 3'h5) && n_sent[0];
  end
endmodule : mss_mac_model
`default_nettype wire

/* File: tb/mss_sampler_tb.sv */
`default_nettype none
module mss_sampler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mss_pkg::*;

  logic        hclk, hresetn, sw_link_clock, hsel, hwrite, hreadyout, hresp, chk_tx;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, sw_mode_code;
  logic [7:0]  n_req, n_sent;
  mss_p5_mii_t p5_strap, p5_wire, p5_pin_o, p5_pin_oe, p5_core_rx;
  mss_sw_rx_t  sw_strap, sw_wire, sw_rx_pin_o, sw_rx_pin_oe, sw_core_rx;
  mss_sw_tx_t  mac_tx, tx_d, sw_core_tx;
  mss_sw_clk_t sw_clk_o, sw_clk_oe;
  mss_cfg_t    cfg;
  int          num_errors, n_compared, cycles;

  // Pin level: device driver where enabled, else the board's strap resistor
  assign p5_wire = (p5_pin_oe & p5_pin_o) | (~p5_pin_oe & p5_strap);
  assign sw_wire = (sw_rx_pin_oe & sw_rx_pin_o) | (~sw_rx_pin_oe & sw_strap);

  mss_sampler dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sw_mode_code(sw_mode_code), .p5_pin_i(p5_wire), .p5_pin_o(p5_pin_o),
    .p5_pin_oe(p5_pin_oe), .p5_core_rx(p5_core_rx), .sw_link_clock(sw_link_clock),
    .sw_rx_pin_i(sw_wire), .sw_rx_pin_o(sw_rx_pin_o), .sw_rx_pin_oe(sw_rx_pin_oe),
    .sw_core_rx(sw_core_rx), .sw_tx_pin_i(mac_tx), .sw_core_tx(sw_core_tx), .sw_clk_o(sw_clk_o),
    .sw_clk_oe(sw_clk_oe), .cfg(cfg)
  );

  mss_mac_model mac (
    .link_clk(sw_link_clock), .rst_n(hresetn), .n_req(n_req), .tx(mac_tx), .n_sent(n_sent)
  );

  // Bus clock 50 ns, link clock 48 ns with an unrelated phase
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    sw_link_clock = 1'b0;
    #7;
    forever #24 sw_link_clock = ~sw_link_clock;
  end

  task results;
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Single AHB-Lite word transfer; a hang is caught by the cycle ceiling
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] w, output logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask : ahb

  // Straps settle during reset, drivers must stay off while it is held
  task do_reset(input logic [2:0] code, input mss_p5_mii_t p5s, input mss_sw_rx_t sws);
    @(posedge hclk);
    hresetn      <= 1'b0;
    sw_mode_code <= code;
    p5_strap     <= p5s;
    sw_strap     <= sws;
    repeat (3) @(posedge hclk);
    #1;
    chk("p5_pin_oe in reset", 32'h0, p5_pin_oe);
    chk("sw_rx_pin_oe in reset", 32'h0, sw_rx_pin_oe);
    chk("sw_clk_oe in reset", 32'h0, sw_clk_oe);
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (12) @(posedge hclk);
    #1;
  endtask : do_reset

  function automatic mss_cfg_t exp_cfg(mss_p5_mii_t p, mss_sw_rx_t s, logic [1:0] c, mss_role_t r);
    mss_cfg_t e;
    e.back_pressure_en   = p.nibble[2];
    e.keep_excess_coll   = p.nibble[1];
    e.aggressive_backoff = p.nibble[0];
    e.max_len_untagged   = p.symbol_error ? MSS_LEN_LONG : MSS_LEN_STD;
    e.max_len_tagged     = p.symbol_error ? MSS_LEN_LONG : MSS_LEN_STD_TAG;
    e.sw_flow_ctrl_en    = s.nibble[3];
    e.sw_half_duplex     = s.nibble[2];
    e.sw_10mbps          = s.nibble[1];
    e.p5_force_duplex    = p.carrier_sense & c[0];
    e.p5_force_flow_ctrl = p.collision & c[1];
    e.role               = r;
    return e;
  endfunction : exp_cfg

  // Compare the core transmit side with the partner's pins one link clock earlier
  always @(posedge sw_link_clock) tx_d <= mac_tx;
  always @(negedge sw_link_clock) begin
    if (chk_tx) begin
      chk("sw_core_tx", tx_d, sw_core_tx);
    end
  end

  // Cycle ceiling against hangs
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    sw_mode_code = 3'h0;
    n_req = 8'h00;
    chk_tx = 1'b0;
    p5_strap = 7'h00;
    sw_strap = 7'h00;
    p5_core_rx = 7'h00;
    sw_core_rx = 7'h00;
    // Every configuration code, straps at their default level
    for (int c = 0; c < 8; c++) begin
      do_reset(c[2:0], 7'h00, 7'h00);
      chk("cfg.role", {30'h0, c[1:0]}, cfg.role);
      chk("sw_clk_oe", {30'h0, {2{c[0]}}}, sw_clk_oe);
      chk("p5_pin_oe", {25'h0, {7{c[2]}}}, p5_pin_oe);
      chk("sw_rx_pin_oe", (c[1:0] != 2'b00) ? 32'h7F : 32'h0, sw_rx_pin_oe);
      ahb(1'b0, MSS_OFS_MODE, 32'h0, rd);
      chk("MODE", {23'h0, 1'b1, 2'b00, c[1:0], 1'b0, c[2:0]}, rd);
    end
    chk("cfg defaults", exp_cfg(7'h00, 7'h00, 2'b00, MSS_ROLE_PHY_SNI), cfg);
    ahb(1'b0, MSS_OFS_STRAP, 32'h0, rd);
    chk("STRAP defaults", 32'h0, rd);
    // PHY role: the device clock pins toggle on every rising bus clock edge
    #1;
    rd[0] = sw_clk_o.tx_clock;
    @(posedge hclk);
    #1;
    chk("sw_clk_o", {30'h0, {2{~rd[0]}}}, sw_clk_o);
    // After reset the pins carry core data, and the caught straps must not follow them
    @(posedge hclk);
    p5_core_rx <= 7'h3F;
    sw_core_rx <= 7'h35;
    repeat (4) @(posedge hclk);
    #1;
    chk("p5_pin_o", 32'h3F, p5_pin_o);
    chk("sw_rx_pin_o", 32'h35, sw_rx_pin_o);
    chk("cfg held", exp_cfg(7'h00, 7'h00, 2'b00, MSS_ROLE_PHY_SNI), cfg);
    // All straps high, MAC-mode role
    do_reset(3'b110, 7'h7F, 7'h7F);
    chk("cfg straps high", exp_cfg(7'h7F, 7'h7F, 2'b00, MSS_ROLE_MAC_MII), cfg);
    ahb(1'b1, MSS_OFS_STRAP, 32'h0, rd);
    ahb(1'b0, MSS_OFS_STRAP, 32'h0, rd);
    chk("STRAP high", 32'h3FF, rd);
    ahb(1'b1, MSS_OFS_CTRL, 32'h3, rd);
    ahb(1'b0, MSS_OFS_CTRL, 32'h0, rd);
    chk("CTRL", 32'h3, rd);
    chk("cfg forced", exp_cfg(7'h7F, 7'h7F, 2'b11, MSS_ROLE_MAC_MII), cfg);
    ahb(1'b1, MSS_OFS_CTRL, 32'h1, rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("cfg duplex only", exp_cfg(7'h7F, 7'h7F, 2'b01, MSS_ROLE_MAC_MII), cfg);
    // Two frames from the partner cross into the bus domain
    @(posedge hclk);
    chk_tx <= 1'b1;
    n_req  <= 8'h02;
    for (int i = 0; i < 400 && n_sent != 8'h02; i++) begin
      @(posedge hclk);
    end
    repeat (10) @(posedge hclk);
    ahb(1'b0, MSS_OFS_FRAMES, 32'h0, rd);
    chk("FRAMES", 32'h2, rd);
    results();
  end
endmodule : mss_sampler_tb
`default_nettype wire
